/* rtl/spm_sequencer.sv */
// spm_sequencer: conversion sequencer, calculation engine, registers
// assumes: register requests arrive on link_clk from a serial slave,
// front end answers each conv_req with one sample on sys_clk
`timescale 1ns/1ps
`default_nettype none
module spm_sequencer
  import spm_pkg::*;
(
  // system
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // register link
  input  wire logic        link_clk,
  input  wire spm_req_t    lk_req,
  output logic             lk_busy,
  output logic             lk_rvalid,
  output logic [15:0]      lk_rdata,
  // convert pin
  input  wire logic        conv_pin,
  // front end
  output logic             conv_req,
  output logic             conv_chan,
  output logic [1:0]       fe_gain,
  output logic             fe_range,
  input  wire spm_smp_t    fe_smp,
  // status
  output logic             op_ok,
  output logic             conversion_ready_flag
);

  typedef enum logic [1:0] {ST_IDLE, ST_WAKE, ST_REQ, ST_WAIT} spm_st_t;

  function automatic logic [2:0] avg_log(input logic [3:0] s);
    avg_log = s[3] ? s[2:0] : 3'h0;
  endfunction

  function automatic logic [15:0] res_cut(input logic [3:0] s,
                                          input logic [15:0] d);
    logic [1:0] drop;
    drop = s[3] ? 2'h0 : 2'(2'h3 - s[1:0]);
    res_cut = d & (16'hffff << drop);
  endfunction

  // =====================================================
  // link domain: request capture
  logic       lk_rs1, lk_rs2;
  logic       lk_tg;
  spm_req_t   lk_hold;
  logic       lk_a1, lk_a2, lk_a3;
  logic       ack_tg;
  logic [15:0] ack_data;
  logic       lk_ack;

  always_ff @(posedge link_clk) begin
    lk_rs1 <= rst;
    lk_rs2 <= lk_rs1;
  end

  always_ff @(posedge link_clk) begin
    if (lk_rs2) begin
      lk_a1 <= 1'b0;
      lk_a2 <= 1'b0;
      lk_a3 <= 1'b0;
    end else begin
      lk_a1 <= ack_tg;
      lk_a2 <= lk_a1;
      lk_a3 <= lk_a2;
    end
  end

  assign lk_ack = lk_a2 ^ lk_a3;

  // requests while busy are ignored
  always_ff @(posedge link_clk) begin
    if (lk_rs2) begin
      lk_busy <= 1'b0;
      lk_tg   <= 1'b0;
      lk_hold <= '0;
    end else if (!lk_busy && (lk_req.wr || lk_req.rd)) begin
      lk_hold <= lk_req;
      lk_tg   <= ~lk_tg;
      lk_busy <= 1'b1;
    end else if (lk_ack) begin
      lk_busy <= 1'b0;
    end
  end

  always_ff @(posedge link_clk) begin
    if (lk_rs2) begin
      lk_rvalid <= 1'b0;
      lk_rdata  <= 16'h0000;
    end else begin
      lk_rvalid <= lk_ack && lk_hold.rd;
      if (lk_ack && lk_hold.rd) begin
        lk_rdata <= ack_data;
      end
    end
  end

  // =====================================================
  // system domain: request arrival
  logic s_r1, s_r2, s_r3;
  logic acc_go, acc_wr, acc_rd;
  logic wr_cfg, rd_stat;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_r1 <= 1'b0;
      s_r2 <= 1'b0;
      s_r3 <= 1'b0;
    end else begin
      s_r1 <= lk_tg;
      s_r2 <= s_r1;
      s_r3 <= s_r2;
    end
  end

  // hold is stable while the toggle is in flight
  assign acc_go  = s_r2 ^ s_r3;
  assign acc_wr  = acc_go && lk_hold.wr;
  assign acc_rd  = acc_go && lk_hold.rd;
  assign wr_cfg  = acc_wr && (lk_hold.addr == A_CFG);
  assign rd_stat = acc_rd && (lk_hold.addr == A_STATUS);

  // =====================================================
  // registers
  logic [15:0] cfg, cal;
  logic [15:0] shunt_result, bus_result;
  logic [15:0] current_result, power_result;
  logic [2:0]  mode, wmode;
  logic [3:0]  savg, bavg;
  logic        w_trig, w_quiet;
  logic [15:0] rd_mux;

  assign mode    = cfg[CFG_MODE_LSB +: 3];
  assign savg    = cfg[CFG_SAVG_LSB +: 4];
  assign bavg    = cfg[CFG_BAVG_LSB +: 4];
  assign wmode   = lk_hold.wdata[CFG_MODE_LSB +: 3];
  assign w_quiet = (wmode == MODE_PD) || (wmode == MODE_OFF);
  assign w_trig  = !wmode[2] && !w_quiet;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg <= CFG_RST;
      cal <= CAL_RST;
    end else if (acc_wr) begin
      if (lk_hold.addr == A_CFG) begin
        cfg <= lk_hold.wdata;
      end
      if (lk_hold.addr == A_CAL) begin
        cal <= lk_hold.wdata;
      end
    end
  end

  always_comb begin
    case (lk_hold.addr)
      A_CFG:     rd_mux = cfg;
      A_SHUNT:   rd_mux = shunt_result;
      A_BUS:     rd_mux = bus_result;
      A_POWER:   rd_mux = power_result;
      A_CURRENT: rd_mux = current_result;
      A_CAL:     rd_mux = cal;
      A_STATUS:  rd_mux = 16'(conversion_ready_flag) << STAT_RDY_BIT;
      default:   rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack_tg   <= 1'b0;
      ack_data <= 16'h0000;
    end else if (acc_go) begin
      ack_tg   <= ~ack_tg;
      ack_data <= rd_mux;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fe_gain  <= CFG_RST[CFG_GAIN_LSB +: 2];
      fe_range <= CFG_RST[CFG_RNG_BIT];
    end else begin
      fe_gain  <= cfg[CFG_GAIN_LSB +: 2];
      fe_range <= cfg[CFG_RNG_BIT];
    end
  end

  // =====================================================
  // convert pin
  logic p_s1, p_s2, p_s3;
  logic pin_go;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      p_s1 <= 1'b0;
      p_s2 <= 1'b0;
      p_s3 <= 1'b0;
    end else begin
      p_s1 <= conv_pin;
      p_s2 <= p_s1;
      p_s3 <= p_s2;
    end
  end

  assign pin_go = p_s2 && !p_s3 && !mode[2] && (mode != MODE_PD);

  // =====================================================
  // sequencer
  spm_st_t     st;
  logic        pd_flag;
  logic [10:0] wake_cnt;
  logic [7:0]  smp_cnt;
  logic [22:0] acc, next_acc;
  logic [2:0]  lg;
  logic [15:0] avg;
  logic        chan_end, calc_go;
  logic        first_ch;

  assign lg       = avg_log(conv_chan ? bavg : savg);
  assign next_acc = acc + (conv_chan
                    ? {7'h00, res_cut(bavg, fe_smp.data)}
                    : {{7{fe_smp.data[15]}}, res_cut(savg, fe_smp.data)});
  assign avg      = 16'($signed(next_acc) >>> lg);
  assign chan_end = (st == ST_WAIT) && fe_smp.valid &&
                    (smp_cnt == 8'((9'h001 << lg) - 9'h001));
  assign first_ch = !mode[0];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pd_flag <= 1'b0;
    end else if (wr_cfg) begin
      pd_flag <= (wmode == MODE_PD);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st        <= ST_REQ;
      conv_chan <= 1'b0;
      conv_req  <= 1'b0;
      wake_cnt  <= 11'h000;
      calc_go   <= 1'b0;
    end else begin
      conv_req <= 1'b0;
      calc_go  <= 1'b0;
      if (wr_cfg) begin
        wake_cnt  <= 11'h000;
        conv_chan <= !wmode[0];
        if (w_quiet) begin
          st <= ST_IDLE;
        end else if (pd_flag) begin
          st <= ST_WAKE;
        end else begin
          st <= ST_REQ;
        end
      end else if (pin_go && st != ST_WAKE) begin
        conv_chan <= first_ch;
        st        <= ST_REQ;
      end else begin
        case (st)
          ST_IDLE: st <= ST_IDLE;
          ST_WAKE: begin
            wake_cnt <= wake_cnt + 11'h001;
            if (wake_cnt == 11'(WAKE_CYC - 1)) begin
              st <= ST_REQ;
            end
          end
          ST_REQ: begin
            conv_req <= 1'b1;
            st       <= ST_WAIT;
          end
          ST_WAIT: begin
            if (chan_end) begin
              if (!conv_chan && mode[1]) begin
                conv_chan <= 1'b1;
                st        <= ST_REQ;
              end else begin
                calc_go   <= 1'b1;
                conv_chan <= first_ch;
                st        <= mode[2] ? ST_REQ : ST_IDLE;
              end
            end else if (fe_smp.valid) begin
              st <= ST_REQ;
            end
          end
          default: st <= ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || st == ST_REQ && smp_cnt == 8'h00) begin
      acc <= 23'h000000;
    end else if (st == ST_WAIT && fe_smp.valid) begin
      acc <= chan_end ? 23'h000000 : next_acc;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || wr_cfg || pin_go || chan_end) begin
      smp_cnt <= 8'h00;
    end else if (st == ST_WAIT && fe_smp.valid) begin
      smp_cnt <= smp_cnt + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      op_ok <= 1'b1;
    end else begin
      op_ok <= !pd_flag && st != ST_WAKE && !(wr_cfg && !w_quiet && pd_flag);
    end
  end

  // =====================================================
  // results with clipping
  logic [16:0] sh_fs;
  logic [15:0] bus_fs;

  assign sh_fs  = 17'({1'b0, SHUNT_FS} << fe_gain);
  assign bus_fs = fe_range ? BUS_FS32 : BUS_FS16;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shunt_result <= 16'h0000;
      bus_result   <= 16'h0000;
    end else if (chan_end) begin
      if (!conv_chan) begin
        if ($signed({avg[15], avg}) > $signed(sh_fs)) begin
          shunt_result <= sh_fs[15:0];
        end else if ($signed({avg[15], avg}) < -$signed(sh_fs)) begin
          shunt_result <= 16'(-sh_fs);
        end else begin
          shunt_result <= avg;
        end
      end else begin
        bus_result <= (avg > bus_fs ? bus_fs : avg) << BUS_SHIFT;
      end
    end
  end

  // =====================================================
  // current and power
  logic        calc2;
  logic [32:0] cur_prod, cur_mag;
  logic [15:0] cur_q;
  logic [15:0] cur_abs;
  logic [28:0] pwr_prod;

  assign cur_prod = 33'($signed(shunt_result) * $signed({1'b0, cal}));
  assign cur_mag  = cur_prod[32] ? 33'(-cur_prod) : cur_prod;
  // truncate toward zero
  assign cur_q    = cur_prod[32] ? 16'(-(cur_mag >> CUR_SHIFT))
                                 : 16'(cur_mag >> CUR_SHIFT);
  assign cur_abs  = current_result[15] ? 16'(-current_result) : current_result;
  assign pwr_prod = 29'(cur_abs * bus_result[15:BUS_SHIFT]);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      calc2          <= 1'b0;
      current_result <= 16'h0000;
      power_result   <= 16'h0000;
    end else begin
      calc2 <= calc_go;
      if (calc_go && cal != CAL_RST) begin
        current_result <= cur_q;
      end
      if (calc2 && cal != CAL_RST) begin
        // power step is twenty current steps
        power_result <= 16'(pwr_prod / PWR_DIV);
      end
    end
  end

  // =====================================================
  // conversion ready; a set wins over a clear
  logic rdy_clr;

  // a pin edge during recovery starts nothing, so it clears nothing
  assign rdy_clr = (wr_cfg && !w_quiet) || rd_stat || (pin_go && st != ST_WAKE);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      conversion_ready_flag <= 1'b0;
    end else if (calc2) begin
      conversion_ready_flag <= 1'b1;
    end else if (rdy_clr) begin
      conversion_ready_flag <= 1'b0;
    end
  end

  // =====================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_off_halts: assert property (
    wr_cfg && wmode == MODE_OFF |=> st == ST_IDLE ##1 !conv_req [*3])
    else $error("converter off still requests samples");

  chk_trig_start: assert property (
    wr_cfg && w_trig && !pd_flag |=> st == ST_REQ ##1 conv_req)
    else $error("triggered write did not start a conversion");

  chk_wake_stay: assert property (
    st == ST_WAKE && wake_cnt != 11'(WAKE_CYC - 1) && !wr_cfg
    |=> st == ST_WAKE && !op_ok)
    else $error("left recovery early");

  chk_cfg_clear: assert property (
    wr_cfg && !w_quiet && !calc2 |=> !conversion_ready_flag)
    else $error("config write did not clear ready");

  chk_quiet_keep: assert property (
    wr_cfg && w_quiet && conversion_ready_flag |=> conversion_ready_flag)
    else $error("quiet mode write cleared ready");

  chk_stat_clear: assert property (
    rd_stat && !calc2 |=> !conversion_ready_flag)
    else $error("status read did not clear ready");

  chk_pin_clear: assert property (
    pin_go && st != ST_WAKE && !wr_cfg && !calc2 |=> !conversion_ready_flag ##1 conv_req)
    else $error("convert pin did not clear ready and start");

  chk_ready_cause: assert property (
    $rose(conversion_ready_flag) |-> $past(calc_go, 2))
    else $error("ready set before calculations ended");

  chk_current_val: assert property (
    calc_go && cal != CAL_RST |=> current_result == $past(cur_q))
    else $error("current result wrong");

  chk_uncal_hold: assert property (
    cal == CAL_RST && !acc_wr |=> $stable(current_result) && $stable(power_result))
    else $error("results changed without calibration");

endmodule
`default_nettype wire

/* rtl/spm_pkg.sv */
// spm_pkg: constants and carriers of the power monitor sequencer
// assumes: one system clock of 40 MHz, register access from a link
// domain of its own, analogue front end outside this block
package spm_pkg;

  // =====================================================
  // register map
  localparam logic [7:0] A_CFG     = 8'h00;
  localparam logic [7:0] A_SHUNT   = 8'h01;
  localparam logic [7:0] A_BUS     = 8'h02;
  localparam logic [7:0] A_POWER   = 8'h03;
  localparam logic [7:0] A_CURRENT = 8'h04;
  localparam logic [7:0] A_CAL     = 8'h05;
  localparam logic [7:0] A_STATUS  = 8'h06;

  // =====================================================
  // fields and reset values
  localparam logic [15:0] CFG_RST = 16'h399f;
  localparam logic [15:0] CAL_RST = 16'h0000;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_SAVG_LSB = 3;
  localparam int CFG_BAVG_LSB = 7;
  localparam int CFG_GAIN_LSB = 11;
  localparam int CFG_RNG_BIT  = 13;
  localparam int STAT_RDY_BIT = 0;
  localparam int BUS_SHIFT    = 3;

  // =====================================================
  // modes: bit2 continuous, bit1 bus, bit0 shunt
  localparam logic [2:0] MODE_PD  = 3'h0;
  localparam logic [2:0] MODE_OFF = 3'h4;

  // =====================================================
  // scaling
  localparam logic [15:0] SHUNT_FS = 16'h0fa0;
  localparam logic [15:0] BUS_FS16 = 16'h0fa0;
  localparam logic [15:0] BUS_FS32 = 16'h1f40;
  localparam int CUR_SHIFT = 12;
  localparam int PWR_DIV   = 5000;

  // =====================================================
  // timing
  localparam int CLK_NS   = 25;
  localparam int WAKE_NS  = 40000;
  localparam int WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } spm_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } spm_smp_t;

endpackage

/* verif/spm_fe_model.sv */
// spm_fe_model: behavioural front end answering sample requests
// assumes: one request outstanding at a time, sys_clk domain only
`timescale 1ns/1ps
`default_nettype none
module spm_fe_model
  import spm_pkg::*;
(
  // system
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // request side
  input  wire logic        conv_req,
  input  wire logic        conv_chan,
  // analogue levels set by the bench
  input  wire logic [15:0] shunt_val,
  input  wire logic [15:0] bus_val,
  // answer
  output var  spm_smp_t    fe_smp
);
  logic [3:0] cnt;
  logic       chan;

  // =====================================================
  // sample answer, six cycles after each request
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt    <= 4'h0;
      chan   <= 1'b0;
      fe_smp <= '0;
    end else begin
      fe_smp.valid <= 1'b0;
      // idle data toggles so a stale read matches only on alternate cycles
      fe_smp.data  <= ~fe_smp.data;
      if (conv_req) begin
        cnt  <= 4'h6;
        chan <= conv_chan;
      end else if (cnt == 4'h1) begin
        cnt          <= 4'h0;
        fe_smp.valid <= 1'b1;
        fe_smp.data  <= chan ? bus_val : shunt_val;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* verif/tb_shunt_power_monitor_sequencer.sv */
// tb_shunt_power_monitor_sequencer: register-level tests of the sequencer
// assumes: front end model of its own, link clock 30 ns, no other stimulus
`timescale 1ns/1ps
`default_nettype none
module tb_shunt_power_monitor_sequencer
  import spm_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        rst;
  spm_req_t    lk_req;
  logic        lk_busy;
  logic        lk_rvalid;
  logic [15:0] lk_rdata;
  logic        conv_pin;
  logic        conv_req;
  logic        conv_chan;
  logic [1:0]  fe_gain;
  logic        fe_range;
  spm_smp_t    fe_smp;
  logic        op_ok;
  logic        flag;
  logic [15:0] shunt_val;
  logic [15:0] bus_val;
  logic [15:0] q;
  int          err_count = 0;
  int          checked = 0;
  int          n_sh = 0;
  int          n_bus = 0;
  int          n_low = 0;
  int          s0;
  int          b0;
  int          k;
  // calibration as a host would pick it for the chosen steps
  logic [15:0] tv_cal[2] = '{16'h2000, 16'h1388};
  logic [15:0] tv_sh[2]  = '{16'h03e8, 16'hfe0c};
  logic [15:0] tv_bus[2] = '{16'h0bb8, 16'h0bb8};
  logic [15:0] tv_cur[2] = '{16'h07d0, 16'hfd9e};
  logic [15:0] tv_pwr[2] = '{16'h04b0, 16'h016e};

  always #12.5 sys_clk = ~sys_clk;
  always #15 link_clk = ~link_clk;

  spm_sequencer u_dut (
    .sys_clk               (sys_clk),
    .rst                   (rst),
    .link_clk              (link_clk),
    .lk_req                (lk_req),
    .lk_busy               (lk_busy),
    .lk_rvalid             (lk_rvalid),
    .lk_rdata              (lk_rdata),
    .conv_pin              (conv_pin),
    .conv_req              (conv_req),
    .conv_chan             (conv_chan),
    .fe_gain               (fe_gain),
    .fe_range              (fe_range),
    .fe_smp                (fe_smp),
    .op_ok                 (op_ok),
    .conversion_ready_flag (flag)
  );

  spm_fe_model u_fe (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .conv_req  (conv_req),
    .conv_chan (conv_chan),
    .shunt_val (shunt_val),
    .bus_val   (bus_val),
    .fe_smp    (fe_smp)
  );

  // =====================================================
  // request counters per channel
  always @(posedge sys_clk) begin
    if (conv_req === 1'b1) begin
      if (conv_chan === 1'b1) n_bus++;
      else n_sh++;
      if (op_ok !== 1'b1) n_low++;
    end
  end

  // =====================================================
  // helpers
  function automatic logic [15:0] cfgw(input logic [2:0] m, input logic [1:0] g,
                                       input logic r);
    return {2'b00, r, g, 4'h8, 4'h9, m};
  endfunction

  task automatic test_done;
    if (err_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic link_xfer(input logic r, input logic w, input logic [7:0] a,
                           input logic [15:0] d, output logic [15:0] rq);
    int i;
    rq = 16'h0;
    @(posedge link_clk);
    lk_req <= '{rd: r, wr: w, addr: a, wdata: d};
    @(posedge link_clk);
    lk_req <= '0;
    #1;
    for (i = 0; i < 80 && lk_busy !== 1'b0; i++) begin
      if (lk_rvalid === 1'b1) rq = lk_rdata;
      @(posedge link_clk);
      #1;
    end
    if (lk_rvalid === 1'b1) rq = lk_rdata;
    if (i == 80) begin
      chk16(16'h0, 16'h1);
      test_done;
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] dummy;
    link_xfer(1'b0, 1'b1, a, d, dummy);
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
    link_xfer(1'b1, 1'b0, a, 16'h0, d);
  endtask

  task automatic wait_flag;
    int i;
    for (i = 0; i < 4000 && flag !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (i == 4000) begin
      chk16(16'h0, 16'h1);
      test_done;
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // =====================================================
  // main sequence
  initial begin
    rst = 1'b1;
    lk_req = '0;
    conv_pin = 1'b0;
    shunt_val = 16'h03e8;
    bus_val = 16'h0bb8;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    wait_cyc(5);
    reg_rd(A_CFG, q); chk16(q, CFG_RST);
    reg_rd(A_CAL, q); chk16(q, CAL_RST);
    chk16({14'h0, fe_gain}, 16'h0003);
    chk16({15'h0, fe_range}, 16'h0001);
    wait_flag;
    reg_rd(A_CURRENT, q); chk16(q, 16'h0000);
    reg_rd(A_POWER, q); chk16(q, 16'h0000);
    // gain and range codes with the converter off
    for (k = 0; k < 4; k++) begin
      reg_wr(A_CFG, cfgw(MODE_OFF, k[1:0], k[0]));
      reg_rd(A_CFG, q); chk16(q, cfgw(MODE_OFF, k[1:0], k[0]));
      chk16({14'h0, fe_gain}, 16'(k));
      chk16({15'h0, fe_range}, {15'h0, k[0]});
    end
    s0 = n_sh + n_bus;
    wait_cyc(300);
    chk16(16'(n_sh + n_bus - s0), 16'h0000);
    chk16({15'h0, flag}, 16'h0001);
    reg_rd(A_STATUS, q); chk16(q, 16'h0001);
    reg_rd(A_STATUS, q); chk16(q, 16'h0000);
    // results of triggered shots with two calibrations
    for (k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      shunt_val <= tv_sh[k];
      bus_val <= tv_bus[k];
      reg_wr(A_CAL, tv_cal[k]);
      reg_wr(A_CFG, cfgw(3'h3, 2'h3, 1'b1));
      chk16({15'h0, flag}, 16'h0000);
      wait_flag;
      reg_rd(A_SHUNT, q); chk16(q, tv_sh[k]);
      reg_rd(A_BUS, q); chk16(q, tv_bus[k] << BUS_SHIFT);
      reg_rd(A_CURRENT, q); chk16(q, tv_cur[k]);
      reg_rd(A_POWER, q); chk16(q, tv_pwr[k]);
    end
    // idle after a shot, results held, read-only and unmapped places
    s0 = n_sh + n_bus;
    wait_cyc(300);
    chk16(16'(n_sh + n_bus - s0), 16'h0000);
    reg_rd(A_CURRENT, q); chk16(q, tv_cur[1]);
    reg_wr(A_POWER, 16'hffff);
    reg_rd(A_POWER, q); chk16(q, tv_pwr[1]);
    reg_rd(8'h07, q); chk16(q, 16'h0000);
    // shunt only, bus only, both; the last repeats the current mode
    for (k = 1; k < 4; k++) begin
      s0 = n_sh;
      b0 = n_bus;
      reg_wr(A_CFG, cfgw(k[2:0], 2'h3, 1'b1));
      wait_flag;
      chk16(16'(n_sh - s0), k[0] ? 16'h0002 : 16'h0000);
      chk16(16'(n_bus - b0), k[1] ? 16'h0001 : 16'h0000);
    end
    // convert pin starts a shot and clears the flag
    s0 = n_sh;
    @(posedge sys_clk);
    conv_pin <= 1'b1;
    wait_cyc(5);
    chk16({15'h0, flag}, 16'h0000);
    @(posedge sys_clk);
    conv_pin <= 1'b0;
    wait_flag;
    chk16(16'(n_sh - s0), 16'h0002);
    // power-down keeps the flag, recovery before conversions
    reg_wr(A_CFG, cfgw(MODE_PD, 2'h3, 1'b1));
    chk16({15'h0, flag}, 16'h0001);
    chk16({15'h0, op_ok}, 16'h0000);
    reg_wr(A_CFG, cfgw(3'h3, 2'h3, 1'b1));
    chk16({15'h0, op_ok}, 16'h0000);
    for (k = 0; k < 2000 && op_ok !== 1'b1; k++) wait_cyc(1);
    chk16({15'h0, k >= WAKE_CYC - 50 && k <= WAKE_CYC}, 16'h0001);
    chk16(16'(n_low), 16'h0000);
    wait_flag;
    // continuous: two shunt samples per bus sample
    s0 = n_sh;
    b0 = n_bus;
    reg_wr(A_CFG, cfgw(3'h7, 2'h3, 1'b1));
    wait_cyc(600);
    reg_wr(A_CFG, cfgw(MODE_OFF, 2'h3, 1'b1));
    s0 = n_sh - s0;
    b0 = n_bus - b0;
    chk16({15'h0, b0 >= 3 && s0 + 2 >= 2 * b0 && s0 <= 2 * b0 + 2}, 16'h0001);
    test_done;
  end
endmodule
`default_nettype wire
